// ==== hdl/icg_clock_source.sv ====
// internal clock generator: source select, divider, stop handling, apb
// assumes one 200 MHz clock; stop request comes from same-domain logic
//
// Contract
// R1 - status bit shows active source, only after synchronised switchover
// R2 - fine adjust bit lengthens or shortens reference period by one step
// R3 - engaged mode after reset and on writing source select to 0
// R4 - engaged mode takes system clock from the loop
// R5 - select 1 with low power 0 gives bypassed mode on reference
// R6 - bypassed mode keeps the loop running and locked
// R7 - select 1 with low power 1 runs reference and disables loop
// R8 - stop disables loop, halts clocks, reference kept if enabled
// R9 - leaving stop resumes the earlier mode; reset gives default mode
// R10 - stop exit waits reference wake or loop re-acquire time
// R11 - software waits acquisition time after low power exit or trim
// R12 - divider change takes effect at once
// R13 - larger coarse code slows reference in all run modes
// R14 - coarse and fine period codes survive every reset
// R15 - system enables low voltage bits before stop to keep running
// R16 - divider resets to divide by two
// R17 - software trims the reference before choosing divide by one
// R18 - fixed clock valid only in engaged mode
// R19 - fixed clock is reference divided by two
// R20 - divider codes 0..3 divide by 1, 2, 4, 8
// R21 - coarse code is binary weighted
// R22 - system clock runs at twice bus clock
// R23 - glitch-free source switch, status follows completed switch
`timescale 1ns/1ps
`default_nettype none
`include "icg_regs.svh"
module icg_clock_source #(
  parameter int ACQ_CYC = `ICG_ACQ_CYC,
  parameter int IR_WU_CYC = `ICG_IR_WU_CYC,
  parameter int FLL_WU_CYC = `ICG_FLL_WU_CYC,
  parameter int REF_BASE = `ICG_LOOP_MULT / 2
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic STOP_REQ,
  output logic SYS_CLK_OUT,
  output logic BUS_CLK_OUT,
  output logic REF_CLK_OUT,
  output logic FF_CLK_OUT,
  output logic FF_CLK_VALID,
  output logic LOOP_ENABLED,
  output logic LOOP_LOCKED
);
  import icg_pkg::*;

  icg_ctrl_s ctrl_q;
  icg_pwr_e state_q;
  logic [7:0] trim_q;
  logic fine_period_adjust_q;
  logic [15:0] wcnt_q;
  logic [9:0] ref_cnt_q;
  logic [9:0] ref_half;
  logic ref_run, ref_tick, src_tick, sw_now, loop_on_d;
  logic [31:0] lock_cnt_q;
  logic sel_s1_q, sel_s2_q, act_sel_q, clock_mode_status_q;
  logic [2:0] div_cnt_q, div_lim;
  logic wr_en, access, trim_wr;
  logic [31:0] rd_d;
  logic hit_d, ctrl2_seen_q;

  // apb decode: writes land at the access edge with pready high
  assign access = PSEL && PENABLE && PREADY;
  assign wr_en = access && PWRITE;
  assign trim_wr = wr_en && PADDR == `ICG_OFF_TRIM;

  // control register writes
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ctrl_q <= '{src_sel: 1'b0, ref_stop: 1'b0,
                 bus_divider: `ICG_BUS_DIVIDER_RST, lp: 1'b0}; // R3 R16
      ctrl2_seen_q <= 1'b0;
    end else if (wr_en) begin
      if (PADDR == `ICG_OFF_CTRL1) begin
        ctrl_q.src_sel <= PWDATA[`ICG_SRC_SEL_BIT]; // R3 R5 R7
        ctrl_q.ref_stop <= PWDATA[`ICG_REF_STOP_BIT];
      end
      if (PADDR == `ICG_OFF_CTRL2) begin
        ctrl_q.bus_divider <= PWDATA[`ICG_BUS_DIVIDER_MSB:`ICG_BUS_DIVIDER_LSB]; // R12
        ctrl_q.lp <= PWDATA[`ICG_LP_BIT];
        ctrl2_seen_q <= 1'b1;
      end
    end
  end

  // period codes have no reset so they survive it
  always_ff @(posedge CLK) begin
    if (trim_wr)
      trim_q <= PWDATA[7:0]; // R14
    if (wr_en && PADDR == `ICG_OFF_STAT)
      fine_period_adjust_q <= PWDATA[`ICG_FINE_PERIOD_ADJUST_BIT]; // R14
  end

  // read mux
  always_comb begin
    rd_d = 32'h0;
    hit_d = 1'b1;
    unique case (PADDR)
      `ICG_OFF_CTRL1: begin
        rd_d[`ICG_SRC_SEL_BIT] = ctrl_q.src_sel;
        rd_d[`ICG_REF_STOP_BIT] = ctrl_q.ref_stop;
      end
      `ICG_OFF_CTRL2: begin
        rd_d[`ICG_BUS_DIVIDER_MSB:`ICG_BUS_DIVIDER_LSB] = ctrl_q.bus_divider;
        rd_d[`ICG_LP_BIT] = ctrl_q.lp;
      end
      `ICG_OFF_TRIM: rd_d[7:0] = trim_q;
      `ICG_OFF_STAT: begin
        rd_d[`ICG_LOCK_BIT] = LOOP_LOCKED;
        rd_d[`ICG_CLOCK_MODE_STATUS_BIT] = clock_mode_status_q; // R1
        rd_d[`ICG_FINE_PERIOD_ADJUST_BIT] = fine_period_adjust_q;
      end
      default: hit_d = 1'b0;
    endcase
  end

  // apb answer: one wait-free access cycle after setup
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0;
    end else begin
      PREADY <= PSEL && !PENABLE;
      PSLVERR <= PSEL && !PENABLE && !hit_d;
      if (PSEL && !PENABLE)
        PRDATA <= PWRITE ? 32'h0 : rd_d;
    end
  end

  // power state: stop, then a timed wake back to the saved mode
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state_q <= ST_RUN;
      wcnt_q <= 16'h0;
    end else begin
      unique case (state_q)
        ST_RUN: if (STOP_REQ) state_q <= ST_STOP; // R8
        ST_STOP: begin
          if (!STOP_REQ) begin
            state_q <= ST_WAKE; // R9
            if (!ctrl_q.ref_stop)
              wcnt_q <= 16'(IR_WU_CYC); // R10
            else if (!act_sel_q)
              wcnt_q <= 16'(FLL_WU_CYC); // R10
            else
              wcnt_q <= 16'h1;
          end
        end
        ST_WAKE: begin
          if (wcnt_q <= 16'h1)
            state_q <= ST_RUN; // R9
          wcnt_q <= wcnt_q - 16'h1;
        end
      endcase
    end
  end

  // reference generator: half period grows with the codes
  assign ref_half = 10'(REF_BASE) + {1'b0, trim_q, fine_period_adjust_q}; // R2 R13 R21
  assign ref_run = state_q != ST_STOP || ctrl_q.ref_stop; // R8
  assign ref_tick = ref_run && ref_cnt_q >= ref_half - 10'h1;
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ref_cnt_q <= 10'h0;
      REF_CLK_OUT <= 1'b0;
      FF_CLK_OUT <= 1'b0;
    end else if (!ref_run) begin
      ref_cnt_q <= 10'h0; // R8
    end else if (ref_tick) begin
      ref_cnt_q <= 10'h0;
      REF_CLK_OUT <= !REF_CLK_OUT;
      if (!REF_CLK_OUT)
        FF_CLK_OUT <= !FF_CLK_OUT; // R19
    end else begin
      ref_cnt_q <= ref_cnt_q + 10'h1;
    end
  end

  // loop enable and acquisition counter; loop ticks every cycle
  // loop stays on until the switch to the reference is done, else the
  // old source could stop with the system clock high and hang the mux
  assign loop_on_d = state_q != ST_STOP
    && !(act_sel_q && ctrl_q.src_sel && ctrl_q.lp); // R6 R7 R8
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      LOOP_ENABLED <= 1'b0;
      lock_cnt_q <= 32'(ACQ_CYC);
      LOOP_LOCKED <= 1'b0;
    end else begin
      LOOP_ENABLED <= loop_on_d;
      if (!LOOP_ENABLED || trim_wr)
        lock_cnt_q <= 32'(ACQ_CYC); // R11
      else if (lock_cnt_q != 32'h0)
        lock_cnt_q <= lock_cnt_q - 32'h1;
      LOOP_LOCKED <= LOOP_ENABLED && lock_cnt_q == 32'h0 && !trim_wr;
    end
  end

  // source select crossing and glitch-free switch at low output
  assign sw_now = state_q == ST_RUN && sel_s2_q != act_sel_q
    && !SYS_CLK_OUT;
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      sel_s1_q <= 1'b0;
      sel_s2_q <= 1'b0;
      act_sel_q <= 1'b0;
      clock_mode_status_q <= 1'b0;
      FF_CLK_VALID <= 1'b0;
    end else begin
      sel_s1_q <= ctrl_q.src_sel;
      sel_s2_q <= sel_s1_q;
      if (sw_now)
        act_sel_q <= sel_s2_q; // R23
      clock_mode_status_q <= act_sel_q; // R1
      FF_CLK_VALID <= state_q == ST_RUN && !act_sel_q; // R18
    end
  end

  // output divider by 1, 2, 4 or 8, bus clock at half system clock
  assign src_tick = act_sel_q ? ref_tick : LOOP_ENABLED; // R4 R5
  assign div_lim = 3'((4'h1 << ctrl_q.bus_divider) - 4'h1); // R20
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      div_cnt_q <= 3'h0;
      SYS_CLK_OUT <= 1'b0;
      BUS_CLK_OUT <= 1'b0;
    end else if (state_q != ST_RUN || sw_now) begin
      div_cnt_q <= 3'h0; // R8 R23
    end else if (src_tick) begin
      if (div_cnt_q >= div_lim) begin
        div_cnt_q <= 3'h0; // R12
        SYS_CLK_OUT <= !SYS_CLK_OUT;
        if (!SYS_CLK_OUT)
          BUS_CLK_OUT <= !BUS_CLK_OUT; // R22
      end else begin
        div_cnt_q <= div_cnt_q + 3'h1;
      end
    end
  end

  // checks
  property p_clock_mode_status_lag;
    @(posedge CLK) disable iff (!NRST)
    $rose(ctrl_q.src_sel) && !act_sel_q |=> !clock_mode_status_q ##1 !clock_mode_status_q;
  endproperty
  a_clock_mode_status_lag: assert property (p_clock_mode_status_lag) // R1
    else $error("status moved before synchronisation");

  property p_bus_divider_rst;
    @(posedge CLK) disable iff (!NRST)
    !ctrl2_seen_q |-> ctrl_q.bus_divider == 2'h1;
  endproperty
  a_bus_divider_rst: assert property (p_bus_divider_rst) // R16
    else $error("divider not at divide by two after reset");

  property p_lp_off;
    @(posedge CLK) disable iff (!NRST)
    ctrl_q.src_sel && ctrl_q.lp && act_sel_q |=> !LOOP_ENABLED;
  endproperty
  a_lp_off: assert property (p_lp_off) // R7
    else $error("loop still on in low power bypass");

  property p_byp_on;
    @(posedge CLK) disable iff (!NRST)
    state_q == ST_RUN && !ctrl_q.lp |=> LOOP_ENABLED;
  endproperty
  a_byp_on: assert property (p_byp_on) // R6
    else $error("loop off in a mode that keeps it");

  property p_stop_halt;
    @(posedge CLK) disable iff (!NRST)
    state_q == ST_STOP && !ctrl_q.ref_stop
      |=> $stable(REF_CLK_OUT) && $stable(SYS_CLK_OUT) && !LOOP_ENABLED;
  endproperty
  a_stop_halt: assert property (p_stop_halt) // R8
    else $error("clock moved in stop");

  property p_ff_valid;
    @(posedge CLK) disable iff (!NRST)
    FF_CLK_VALID |-> !clock_mode_status_q && LOOP_ENABLED;
  endproperty
  a_ff_valid: assert property (p_ff_valid) // R18
    else $error("fixed clock valid outside engaged mode");

  property p_ff_half;
    @(posedge CLK) disable iff (!NRST)
    $changed(FF_CLK_OUT) |-> $rose(REF_CLK_OUT);
  endproperty
  a_ff_half: assert property (p_ff_half) // R19
    else $error("fixed clock not on reference rising edge");

  property p_wake_ref;
    @(posedge CLK) disable iff (!NRST)
    state_q == ST_STOP && !STOP_REQ && !ctrl_q.ref_stop
      |=> state_q == ST_WAKE && wcnt_q == 16'(IR_WU_CYC);
  endproperty
  a_wake_ref: assert property (p_wake_ref) // R10
    else $error("reference wake time not applied");

  property p_div_now;
    @(posedge CLK) disable iff (!NRST)
    state_q == ST_RUN && !sw_now && src_tick && div_cnt_q >= div_lim
      |=> $changed(SYS_CLK_OUT);
  endproperty
  a_div_now: assert property (p_div_now) // R12
    else $error("divider limit did not toggle output");
endmodule // icg_clock_source
`default_nettype wire

// ==== hdl/icg_regs.svh ====
// register offsets, field positions, reset values and timing figures
// for the internal clock generator; included by the top module
`ifndef ICG_REGS_SVH
`define ICG_REGS_SVH
// register byte offsets on the 12-bit apb address
`define ICG_OFF_CTRL1 12'h000
`define ICG_OFF_CTRL2 12'h004
`define ICG_OFF_TRIM 12'h008
`define ICG_OFF_STAT 12'h00C
// field positions
`define ICG_SRC_SEL_BIT 6
`define ICG_REF_STOP_BIT 0
`define ICG_BUS_DIVIDER_MSB 7
`define ICG_BUS_DIVIDER_LSB 6
`define ICG_LP_BIT 3
`define ICG_LOCK_BIT 7
`define ICG_CLOCK_MODE_STATUS_BIT 2
`define ICG_FINE_PERIOD_ADJUST_BIT 0
// reset values
`define ICG_BUS_DIVIDER_RST 2'h1
// loop multiplies the reference by this factor
`define ICG_LOOP_MULT 512
// clock rate and wait times
`define ICG_CLK_MHZ 200
`define ICG_T_IR_WU_NS 5000
`define ICG_T_FLL_WU_NS 20000
`define ICG_T_ACQ_NS 1000000
`define ICG_IR_WU_CYC ((`ICG_T_IR_WU_NS * `ICG_CLK_MHZ + 999) / 1000)
`define ICG_FLL_WU_CYC ((`ICG_T_FLL_WU_NS * `ICG_CLK_MHZ + 999) / 1000)
`define ICG_ACQ_CYC ((`ICG_T_ACQ_NS * `ICG_CLK_MHZ + 999) / 1000)
`endif

// ==== hdl/icg_pkg.sv ====
// types of the internal clock generator
// assumes icg_regs.svh on the include path
`default_nettype none
package icg_pkg;
  // power state of the generator
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_STOP = 3'b010,
    ST_WAKE = 3'b100
  } icg_pwr_e;
  // software control fields
  typedef struct packed {
    logic src_sel;
    logic ref_stop;
    logic [1:0] bus_divider;
    logic lp;
  } icg_ctrl_s;
endpackage
`default_nettype wire

// ==== test/icg_stop_model.sv ====
// model of the mcu power controller that drives the stop request
// assumes the bench asks for stop with want_stop on the generator clock
`timescale 1ns/1ps
`default_nettype none
module icg_stop_model #(
  parameter bit LVD_OK = 1'b1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic want_stop,
  output logic stop_req
);
  // stop only with LVD_OK set; release is the wake
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stop_req <= 1'b0;
    end else begin
      stop_req <= want_stop & LVD_OK;
    end
  end
endmodule // icg_stop_model
`default_nettype wire

// ==== test/tb.sv ====
// directed bench for the clock generator over apb
// assumes the design and the stop model are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module tb;
  logic CLK = 1'b0;
  logic NRST = 1'b0;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic want = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA;
  logic [31:0] rd;
  logic PREADY, PSLVERR, STOP_REQ, SYS, BUS, REF, FF, FFV, LEN, LLK, er;
  logic [3:0] cl;
  int err_count = 0;
  int checked = 0;
  int n, m;
  assign cl = {FF, REF, BUS, SYS};
  // clock
  always #2.5 CLK = ~CLK;
  icg_clock_source #(.ACQ_CYC(50), .IR_WU_CYC(10), .FLL_WU_CYC(30),
    .REF_BASE(4)) u_icg_clock_source (.CLK(CLK), .NRST(NRST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .STOP_REQ(STOP_REQ), .SYS_CLK_OUT(SYS), .BUS_CLK_OUT(BUS),
    .REF_CLK_OUT(REF), .FF_CLK_OUT(FF), .FF_CLK_VALID(FFV),
    .LOOP_ENABLED(LEN), .LOOP_LOCKED(LLK));
  icg_stop_model u_icg_stop_model (.clk(CLK), .nrst(NRST),
    .want_stop(want), .stop_req(STOP_REQ));
  // one apb transfer; answer taken at the edge where pready is high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    // pready, read data and error are taken at the rising edge itself
    do begin
      @(posedge CLK);
      k++;
    end while (PREADY !== 1'b1 && k < 50);
    if (PREADY !== 1'b1) err_count++;
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  // period of one clock output in cycles, rise to rise
  task automatic per(input int s, output int p);
    int r;
    logic o;
    r = -1;
    p = 0;
    for (int k = 0; k < 3000 && p == 0; k++) begin
      o = cl[s];
      @(negedge CLK);
      if (cl[s] === 1'b1 && o === 1'b0) begin
        if (r >= 0) p = k - r;
        r = k;
      end
    end
  endtask
  // count changes of one clock output over c cycles
  task automatic tog(input int s, input int c, output int t);
    logic o;
    t = 0;
    repeat (c) begin
      o = cl[s];
      @(negedge CLK);
      if (cl[s] !== o) t++;
    end
  endtask
  // stop, count reference and system clock changes, then ask for wake
  task automatic stop_wake(output int t, output int u);
    @(posedge CLK);
    want <= 1'b1;
    repeat (10) @(negedge CLK);
    tog(2, 40, t);
    tog(0, 40, u);
    `CHK(LEN, 1'b0)
    @(posedge CLK);
    want <= 1'b0;
  endtask
  task automatic close_out;
    if (err_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (20000) @(posedge CLK);
    err_count++;
    close_out();
  end
  // main sequence
  initial begin
    repeat (16) @(posedge CLK);
    NRST <= 1'b1;
    apb(1'b0, 12'h004, 32'h0);
    `CHK(rd[7:0], 8'h40)
    apb(1'b0, 12'h00C, 32'h0);
    `CHK(rd[2], 1'b0)
    apb(1'b1, 12'h010, 32'hFF);
    `CHK(er, 1'b1)
    apb(1'b1, 12'h008, 32'h1);
    apb(1'b1, 12'h00C, 32'h0);
    per(2, n);
    `CHK(n, 12)
    apb(1'b1, 12'h00C, 32'h1);
    per(2, n);
    `CHK(n, 14)
    apb(1'b1, 12'h008, 32'h2);
    per(2, n);
    `CHK(n, 18)
    per(3, m);
    `CHK(m, 36)
    for (int k = 0; k < 200 && LLK !== 1'b1; k++) @(negedge CLK);
    `CHK(LLK, 1'b1)
    `CHK(FFV, 1'b1)
    `CHK(LEN, 1'b1)
    for (int d = 0; d < 4; d++) begin
      apb(1'b1, 12'h004, 32'(d << 6));
      per(0, n);
      `CHK(n, 2 << d)
      per(1, m);
      `CHK(m, 2 * n)
    end
    apb(1'b1, 12'h004, 32'h0);
    apb(1'b1, 12'h000, 32'h40);
    repeat (8) @(negedge CLK);
    apb(1'b0, 12'h00C, 32'h0);
    `CHK(rd[2], 1'b1)
    `CHK(LEN, 1'b1)
    `CHK(FFV, 1'b0)
    per(0, n);
    `CHK(n, 18)
    stop_wake(n, m);
    `CHK(n, 0)
    `CHK(m, 0)
    tog(0, 8, n);
    `CHK(n, 0)
    repeat (20) @(negedge CLK);
    apb(1'b0, 12'h00C, 32'h0);
    `CHK(rd[2], 1'b1)
    apb(1'b1, 12'h000, 32'h41);
    stop_wake(n, m);
    `CHK(n > 0, 1'b1)
    `CHK(m, 0)
    repeat (30) @(negedge CLK);
    apb(1'b1, 12'h004, 32'h8);
    repeat (4) @(negedge CLK);
    `CHK(LEN, 1'b0)
    per(0, n);
    `CHK(n, 18)
    apb(1'b1, 12'h000, 32'h0);
    repeat (8) @(negedge CLK);
    apb(1'b0, 12'h00C, 32'h0);
    `CHK(rd[2], 1'b0)
    `CHK(FFV, 1'b1)
    apb(1'b1, 12'h000, 32'h1);
    stop_wake(n, m);
    `CHK(n > 0, 1'b1)
    `CHK(m, 0)
    tog(0, 24, n);
    `CHK(n, 0)
    tog(0, 20, n);
    `CHK(n > 0, 1'b1)
    @(posedge CLK);
    NRST <= 1'b0;
    repeat (4) @(posedge CLK);
    NRST <= 1'b1;
    apb(1'b0, 12'h008, 32'h0);
    `CHK(rd[7:0], 8'h02)
    apb(1'b0, 12'h00C, 32'h0);
    `CHK(rd[0], 1'b1)
    apb(1'b0, 12'h004, 32'h0);
    `CHK(rd[7:0], 8'h40)
    close_out();
  end
endmodule // tb
`default_nettype wire
